// ### rtl/uamc_pkg.sv
// package of register offsets, field positions, reset values and codes
// assumes a 32-bit word register port with one-cycle read latency
// Contract
// - guard value zero disables guard; 1..255 inserts that many idle bit periods
// - smart-card mode with ratio zero produces no baud clock
// - smart-card baud equals card clock over ratio 1..2047; resets to 0x174
// - errors in smart-card transfer counted in 8 bits; reading clears counter
// - 8-bit writable value sets infrared demodulator filter
// - tx preamble length zero suppresses preamble; 1..15 bit periods otherwise
// - tx pattern: 00 ones, 01 zeros, 10 zero-one, 11 one-zero
// - polarity 0: zero rises mid-bit, one falls; 1 inverts; tx and rx separate
// - rx preamble length zero disables detection; 1..15 bit periods expected
// - rx pattern: 00 ones, 01 zeros, 10 zero-one, 11 one-zero
// - drift bit set tolerates drift and needs 16x oversampling
// - node action 00 transmit, 01 receive, 10 ignore, 11 reserved
// - parity off 0: master appends parity, both check; 1: none
// - checksum off 0: master sends, slave checks; 1: none either role
// - checksum variant 0 enhanced, 1 classic
// - length source 0 uses length field; 1 decodes identifier bits 5 and 6
// - length field value n gives n plus one response bytes
// - frame slot off 0 enables frame slot timing, 1 disables
// - wakeup command sends new-style wakeup for variant 0, old-style for 1
// - dma mode 1 lets dma write lin config except that bit; 0 never
// - mode code 0xa selects lin master, 0xb lin slave
// - identifier writable in master; read-only last received in slave
package uamc_pkg;
    // ============
    // register offsets
    localparam logic [31:0] UAMC_OFS_GUARD = 32'hfff8c028;
    localparam logic [31:0] UAMC_OFS_RATIO = 32'hfff8c040;
    localparam logic [31:0] UAMC_OFS_ERRS  = 32'hfff8c044;
    localparam logic [31:0] UAMC_OFS_IRF   = 32'hfff8c04c;
    localparam logic [31:0] UAMC_OFS_MAN   = 32'hfff8c050;
    localparam logic [31:0] UAMC_OFS_LIN   = 32'hfff8c054;
    localparam logic [31:0] UAMC_OFS_LINID = 32'hfff8c058;
    // ============
    // reset values
    localparam logic [10:0] UAMC_RATIO_RST = 11'h174;
    // ============
    // manchester field positions
    localparam int UAMC_TX_PREAMBLE_LENGTH_LSB = 0;
    localparam int UAMC_TX_PREAMBLE_PATTERN_LSB = 8;
    localparam int UAMC_TX_POL    = 12;
    localparam int UAMC_RX_PREAMBLE_LENGTH_LSB = 16;
    localparam int UAMC_RX_PREAMBLE_PATTERN_LSB = 24;
    localparam int UAMC_RX_POL    = 28;
    localparam int UAMC_DRIFT     = 30;
    // ============
    // lin field positions
    localparam int UAMC_NODE_RESPONSE_ACTION_LSB  = 0;
    localparam int UAMC_ID_PARITY_OFF    = 2;
    localparam int UAMC_CHECKSUM_OFF    = 3;
    localparam int UAMC_CHECKSUM_VARIANT    = 4;
    localparam int UAMC_DLM       = 5;
    localparam int UAMC_FRAME_SLOT_OFF     = 6;
    localparam int UAMC_WKTYP     = 7;
    localparam int UAMC_DLC_LSB   = 8;
    localparam int UAMC_DMAW      = 16;
    // ============
    // operating mode, node action and preamble pattern codes
    localparam logic [3:0] UAMC_MODE_CARD   = 4'h4;
    localparam logic [3:0] UAMC_MODE_LIN_M  = 4'ha;
    localparam logic [3:0] UAMC_MODE_LIN_S  = 4'hb;
    localparam logic [1:0] UAMC_NODE_RESPONSE_ACTION_RSVD   = 2'h3;
    typedef enum logic [1:0] {UAMC_PP_ONES, UAMC_PP_ZEROS, UAMC_PP_ZO, UAMC_PP_OZ} uamc_pp_t;
endpackage

// ### rtl/uamc_baud.sv
// smart-card baud divider: one tick per ratio card-clock ticks
// assumes card_tick is a one-cycle pulse on clk_sys
`timescale 1ns/1ps
module uamc_baud (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic        card_mode,
    input  wire logic [10:0] ratio,
    input  wire logic        card_tick,
    output logic             baud_tick
);
    import uamc_pkg::*;
    typedef struct packed {
        logic [10:0] cnt;
        logic        tick;
    } uamc_baud_st_t;
    uamc_baud_st_t s_q, s_d;

    // ratio zero stops the divider entirely
    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        if (!card_mode || ratio == 11'h000) begin
            s_d.cnt = 11'h000;
        end else if (card_tick) begin
            if (s_q.cnt + 11'h001 >= ratio) begin
                s_d.cnt  = 11'h000;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 11'h001;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end
    assign baud_tick = s_q.tick;

    a_no_tick_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && ratio == 11'h000 |=> !baud_tick) else $error("baud tick with zero ratio");
endmodule

// ### rtl/uamc_guard.sv
// guard and preamble timer: counts bit periods for a started delay
// assumes bit_tick is a one-cycle pulse per bit period
`timescale 1ns/1ps
module uamc_guard (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    input  wire logic       start,
    input  wire logic [7:0] length,
    input  wire logic       bit_tick,
    output logic            busy
);
    import uamc_pkg::*;
    typedef struct packed {
        logic [7:0] left;
    } uamc_guard_st_t;
    uamc_guard_st_t s_q, s_d;

    // zero length never arms the timer
    always_comb begin
        s_d = s_q;
        if (start) begin
            s_d.left = length;
        end else if (bit_tick && s_q.left != 8'h00) begin
            s_d.left = s_q.left - 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end
    assign busy = s_q.left != 8'h00;
endmodule

// ### rtl/uamc_top.sv
// auxiliary mode configuration of the serial transceiver
// assumes a plain register port on clk_sys and core events on the same clock
`timescale 1ns/1ps
module uamc_top (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [3:0]  op_mode,
    input  wire logic        card_tick,
    input  wire logic        bit_tick,
    input  wire logic        card_error,
    input  wire logic        char_done,
    input  wire logic        frame_start,
    input  wire logic        send_wakeup_cmd,
    input  wire logic        dma_wr,
    input  wire logic [31:0] dma_wdata,
    input  wire logic        id_rx_valid,
    input  wire logic [7:0]  id_rx_byte,
    output logic             baud_tick,
    output logic             guard_busy,
    output logic             tx_preamble_busy,
    output logic             tx_preamble_bit,
    output logic [7:0]       ir_filter,
    output logic             rx_preamble_on,
    output logic [3:0]       rx_preamble_length,
    output logic             rx_preamble_bit,
    output logic             tx_line_code_polarity,
    output logic             rx_line_code_polarity,
    output logic             drift_on,
    output logic             lin_master,
    output logic             lin_slave,
    output logic             tx_response,
    output logic             rx_response,
    output logic             gen_parity,
    output logic             chk_parity,
    output logic             gen_checksum,
    output logic             chk_checksum,
    output logic             enhanced_checksum,
    output logic [8:0]       response_bytes,
    output logic             frame_slot_on,
    output logic             wakeup_pulse,
    output logic             wakeup_new_style,
    output logic [7:0]       identifier_byte
);
    import uamc_pkg::*;

    // ============
    // state
    typedef struct packed {
        logic [7:0]  guard_bit_count;
        logic [10:0] card_clock_ratio;
        logic [7:0]  card_error_total;
        logic [7:0]  ir_filter;
        logic [31:0] man;
        logic [16:0] lin;
        logic [7:0]  ident;
        logic [31:0] rdata;
        logic        wk;
        logic        wk_type;
        logic        pre_phase;
    } uamc_st_t;
    uamc_st_t s_q, s_d;

    logic card_mode;
    logic pre_start;
    logic tx_preamble_length_zero;

    // ============
    // decode helpers
    function automatic logic hit(input logic [31:0] a, input logic [31:0] ofs);
        return a == ofs;
    endfunction

    // preamble bit from pattern and phase, before line polarity
    function automatic logic pp_bit(input logic [1:0] pp, input logic ph);
        unique case (uamc_pp_t'(pp))
            UAMC_PP_ONES:  pp_bit = 1'b1;
            UAMC_PP_ZEROS: pp_bit = 1'b0;
            UAMC_PP_ZO:    pp_bit = ph;
            UAMC_PP_OZ:    pp_bit = !ph;
        endcase
    endfunction

    assign card_mode  = op_mode == UAMC_MODE_CARD;
    assign lin_master = op_mode == UAMC_MODE_LIN_M;
    assign lin_slave  = op_mode == UAMC_MODE_LIN_S;

    // ============
    // register and event update
    always_comb begin
        s_d       = s_q;
        s_d.wk    = 1'b0;
        s_d.rdata = 32'h0000_0000;
        if (reg_wr) begin
            if (hit(reg_addr, UAMC_OFS_GUARD)) s_d.guard_bit_count = reg_wdata[7:0];
            if (hit(reg_addr, UAMC_OFS_RATIO)) s_d.card_clock_ratio = reg_wdata[10:0];
            if (hit(reg_addr, UAMC_OFS_IRF))   s_d.ir_filter = reg_wdata[7:0];
            if (hit(reg_addr, UAMC_OFS_MAN)) begin
                s_d.man = reg_wdata & 32'h530f_130f;
            end
            if (hit(reg_addr, UAMC_OFS_LIN)) begin
                s_d.lin = reg_wdata[16:0];
                // wakeup command shares the lin word at bit 17
                s_d.wk      = reg_wdata[17];
                s_d.wk_type = reg_wdata[UAMC_WKTYP];
            end
            if (hit(reg_addr, UAMC_OFS_LINID) && lin_master) begin
                s_d.ident = reg_wdata[7:0];
            end
        end
        if (send_wakeup_cmd) begin
            s_d.wk      = 1'b1;
            s_d.wk_type = s_q.lin[UAMC_WKTYP];
        end
        // dma keeps its own enable bit untouched
        if (dma_wr && s_q.lin[UAMC_DMAW]) begin
            s_d.lin[15:0] = dma_wdata[15:0];
        end
        if (lin_slave && id_rx_valid) begin
            s_d.ident = id_rx_byte;
        end
        // read mux
        if (reg_rd) begin
            if (hit(reg_addr, UAMC_OFS_GUARD)) s_d.rdata = {24'h000000, s_q.guard_bit_count};
            if (hit(reg_addr, UAMC_OFS_RATIO)) s_d.rdata = {21'h000000, s_q.card_clock_ratio};
            if (hit(reg_addr, UAMC_OFS_ERRS))  s_d.rdata = {24'h000000, s_q.card_error_total};
            if (hit(reg_addr, UAMC_OFS_IRF))   s_d.rdata = {24'h000000, s_q.ir_filter};
            if (hit(reg_addr, UAMC_OFS_MAN))   s_d.rdata = s_q.man;
            if (hit(reg_addr, UAMC_OFS_LIN))   s_d.rdata = {15'h0000, s_q.lin};
            if (hit(reg_addr, UAMC_OFS_LINID)) s_d.rdata = {24'h000000, s_q.ident};
        end
        // read clears the counter, but an error in the same cycle still counts
        if (reg_rd && hit(reg_addr, UAMC_OFS_ERRS)) begin
            s_d.card_error_total = 8'h00;
        end
        if (card_mode && card_error) begin
            s_d.card_error_total = (reg_rd && hit(reg_addr, UAMC_OFS_ERRS)) ? 8'h01
                                 : s_q.card_error_total + 8'h01;
        end
        // alternate preamble phase every bit period
        if (pre_start) begin
            s_d.pre_phase = 1'b0;
        end else if (bit_tick) begin
            s_d.pre_phase = !s_q.pre_phase;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_q                  <= '0;
            s_q.card_clock_ratio <= UAMC_RATIO_RST;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // ============
    // timers
    uamc_baud u_baud (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .card_mode (card_mode),
        .ratio     (s_q.card_clock_ratio),
        .card_tick (card_tick),
        .baud_tick (baud_tick)
    );

    // guard restarts after each character; zero never arms it
    uamc_guard u_guard (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .start    (char_done),
        .length   (s_q.guard_bit_count),
        .bit_tick (bit_tick),
        .busy     (guard_busy)
    );

    assign tx_preamble_length_zero = s_q.man[UAMC_TX_PREAMBLE_LENGTH_LSB +: 4] == 4'h0;
    assign pre_start  = frame_start && !tx_preamble_length_zero;

    uamc_guard u_pre (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .start    (pre_start),
        .length   ({4'h0, s_q.man[UAMC_TX_PREAMBLE_LENGTH_LSB +: 4]}),
        .bit_tick (bit_tick),
        .busy     (tx_preamble_busy)
    );

    // ============
    // outputs; polarity inverts the pattern as seen on the line
    assign tx_line_code_polarity = s_q.man[UAMC_TX_POL];
    assign rx_line_code_polarity = s_q.man[UAMC_RX_POL];
    assign tx_preamble_bit = pp_bit(s_q.man[UAMC_TX_PREAMBLE_PATTERN_LSB +: 2], s_q.pre_phase)
                             ^ s_q.man[UAMC_TX_POL];
    assign rx_preamble_length = s_q.man[UAMC_RX_PREAMBLE_LENGTH_LSB +: 4];
    assign rx_preamble_on     = rx_preamble_length != 4'h0;
    assign rx_preamble_bit = pp_bit(s_q.man[UAMC_RX_PREAMBLE_PATTERN_LSB +: 2], s_q.pre_phase)
                             ^ s_q.man[UAMC_RX_POL];
    assign drift_on  = s_q.man[UAMC_DRIFT];
    assign ir_filter = s_q.ir_filter;
    assign reg_rdata = s_q.rdata;

    // lin options; reserved action code does neither
    assign tx_response = s_q.lin[UAMC_NODE_RESPONSE_ACTION_LSB +: 2] == 2'h0;
    assign rx_response = s_q.lin[UAMC_NODE_RESPONSE_ACTION_LSB +: 2] == 2'h1;
    assign gen_parity  = lin_master && !s_q.lin[UAMC_ID_PARITY_OFF];
    assign chk_parity  = (lin_master || lin_slave) && !s_q.lin[UAMC_ID_PARITY_OFF];
    assign gen_checksum = lin_master && !s_q.lin[UAMC_CHECKSUM_OFF];
    assign chk_checksum = lin_slave && !s_q.lin[UAMC_CHECKSUM_OFF];
    assign enhanced_checksum = !s_q.lin[UAMC_CHECKSUM_VARIANT];
    // identifier bits 6:5 give 2, 2, 4 or 8 bytes
    always_comb begin
        if (!s_q.lin[UAMC_DLM]) begin
            response_bytes = {1'b0, s_q.lin[UAMC_DLC_LSB +: 8]} + 9'h001;
        end else begin
            unique case (s_q.ident[6:5])
                2'h0:    response_bytes = 9'h002;
                2'h1:    response_bytes = 9'h002;
                2'h2:    response_bytes = 9'h004;
                default: response_bytes = 9'h008;
            endcase
        end
    end
    assign frame_slot_on    = !s_q.lin[UAMC_FRAME_SLOT_OFF];
    assign wakeup_pulse     = s_q.wk;
    assign wakeup_new_style = !s_q.wk_type;
    assign identifier_byte  = s_q.ident;

    // ============
    // checks
    a_err_clear_rd: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && reg_rd && reg_addr == UAMC_OFS_ERRS && !card_error
        |=> s_q.card_error_total == 8'h00) else $error("error count not cleared");
    a_err_count_up: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && card_mode && card_error && !reg_rd
        |=> s_q.card_error_total == $past(s_q.card_error_total) + 8'h01) else $error("error not counted");
    a_ratio_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(rst_b) |-> s_q.card_clock_ratio == 11'h174) else $error("ratio reset wrong");
    a_pre_zero_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
        tx_preamble_length_zero && !tx_preamble_busy |=> !tx_preamble_busy) else $error("preamble with zero length");
    a_dma_keep_bit: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && dma_wr && !(reg_wr && reg_addr == UAMC_OFS_LIN)
        |=> s_q.lin[UAMC_DMAW] == $past(s_q.lin[UAMC_DMAW])) else $error("dma changed its own bit");
    a_dma_blocked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && dma_wr && !s_q.lin[UAMC_DMAW] && !(reg_wr && reg_addr == UAMC_OFS_LIN)
        |=> $stable(s_q.lin)) else $error("dma wrote while disabled");
    a_id_slave_ro: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && lin_slave && !id_rx_valid |=> $stable(s_q.ident)) else $error("slave id changed");
    a_len_field: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !s_q.lin[UAMC_DLM] |-> response_bytes == {1'b0, s_q.lin[15:8]} + 9'h001) else $error("length wrong");
    a_parity_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_q.lin[UAMC_ID_PARITY_OFF] |-> !gen_parity && !chk_parity) else $error("parity active when off");
    a_guard_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && char_done && s_q.guard_bit_count == 8'h00 |=> !guard_busy) else $error("guard armed at zero");
    c_card_err: cover property (@(posedge clk_sys) card_mode && card_error);
    c_baud: cover property (@(posedge clk_sys) baud_tick);
    c_wakeup: cover property (@(posedge clk_sys) wakeup_pulse);
endmodule

// ### tb/uamc_far_node.sv
// far-side model: card clock, bit clock, card errors and received identifiers
// assumes one clock domain; bench requests arrive as one-cycle pulses
`timescale 1ns/1ps
module uamc_far_node #(
    parameter int CARD_DIV = 2,
    parameter int BIT_DIV  = 4
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       err_req,
    input  wire logic       id_req,
    input  wire logic [7:0] id_val,
    output logic            card_tick,
    output logic            bit_tick,
    output logic            card_error,
    output logic            id_rx_valid,
    output logic [7:0]      id_rx_byte
);
    int         card_cnt;
    int         bit_cnt;
    logic [7:0] last_id;
    // ============
    // dividers and event replay, one cycle behind the request
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            card_cnt    <= 0;
            bit_cnt     <= 0;
            card_error  <= 1'b0;
            id_rx_valid <= 1'b0;
            last_id     <= 8'h00;
        end else begin
            card_cnt    <= (card_cnt == CARD_DIV - 1) ? 0 : card_cnt + 1;
            bit_cnt     <= (bit_cnt == BIT_DIV - 1) ? 0 : bit_cnt + 1;
            card_error  <= err_req;
            id_rx_valid <= id_req;
            if (id_req) begin
                last_id <= id_val;
            end
        end
    end
    // idle id bus shows the inverse of the last byte so a stale copy never passes
    assign card_tick  = (card_cnt == CARD_DIV - 1);
    assign bit_tick   = (bit_cnt == BIT_DIV - 1);
    assign id_rx_byte = id_rx_valid ? last_id : ~last_id;
endmodule

// ### tb/tb_usart_aux_mode_config.sv
// self-checking bench for the auxiliary mode configuration block
// assumes the far-side model supplies ticks, card errors and identifiers
`timescale 1ns/1ps
module tb_usart_aux_mode_config;
    import uamc_pkg::*;
    localparam int BIT_DIV = 4;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        clk_en = 1'b1;
    logic [31:0] reg_addr = 32'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] dma_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [3:0]  op_mode = 4'h0;
    logic [5:0]  pul = 6'h00;
    logic [7:0]  id_val = 8'h00;
    logic [31:0] reg_rdata;
    logic [7:0]  ir_filter, identifier_byte, id_rx_byte;
    logic [3:0]  rx_preamble_length;
    logic [8:0]  response_bytes;
    logic        card_tick, bit_tick, card_error, id_rx_valid, baud_tick, guard_busy, tx_preamble_busy;
    logic        tx_preamble_bit, rx_preamble_on, rx_preamble_bit, tx_line_code_polarity, rx_line_code_polarity;
    logic        drift_on, lin_master, lin_slave, tx_response, rx_response, gen_parity, chk_parity;
    logic        gen_checksum, chk_checksum, enhanced_checksum, frame_slot_on, wakeup_pulse, wakeup_new_style;
    int          bad_count = 0;
    int          n_checks = 0;
    int          ones;
    // ============
    // design and far side; pul bits: guard start, preamble start, wakeup, error, dma, identifier
    uamc_top dut_u (
        .clk_sys, .rst_b, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .op_mode,
        .card_tick, .bit_tick, .card_error, .char_done(pul[0]), .frame_start(pul[1]),
        .send_wakeup_cmd(pul[2]), .dma_wr(pul[4]), .dma_wdata, .id_rx_valid, .id_rx_byte,
        .baud_tick, .guard_busy, .tx_preamble_busy, .tx_preamble_bit, .ir_filter, .rx_preamble_on,
        .rx_preamble_length, .rx_preamble_bit, .tx_line_code_polarity, .rx_line_code_polarity,
        .drift_on, .lin_master, .lin_slave, .tx_response, .rx_response, .gen_parity, .chk_parity,
        .gen_checksum, .chk_checksum, .enhanced_checksum, .response_bytes, .frame_slot_on,
        .wakeup_pulse, .wakeup_new_style, .identifier_byte
    );
    uamc_far_node #(.CARD_DIV(2), .BIT_DIV(BIT_DIV)) far_u (
        .clk_sys, .rst_b, .err_req(pul[3]), .id_req(pul[5]), .id_val, .card_tick, .bit_tick,
        .card_error, .id_rx_valid, .id_rx_byte
    );
    always #2 clk_sys = ~clk_sys;
    // ============
    // shared helpers
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(what, reg_rdata, exp);
    endtask
    task automatic pulse(input int i);
        @(posedge clk_sys);
        pul <= pul | (6'h01 << i);
        @(posedge clk_sys);
        pul <= pul & ~(6'h01 << i);
    endtask
    // busy span in cycles, counted from the start edge on
    task automatic busy_len(input bit prb, output int c);
        logic b;
        c = 0;
        ones = 0;
        for (int k = 0; k < 1100; k++) begin
            #1 b = prb ? tx_preamble_busy : guard_busy;
            if (b === 1'b1) begin
                c++;
                ones += (tx_preamble_bit === 1'b1);
            end else if (c > 0 || k > 3) begin
                break;
            end
            @(posedge clk_sys);
        end
    endtask
    task automatic wk_chk(input int t);
        int c;
        #1 c = (wakeup_pulse === 1'b1);
        repeat (4) @(posedge clk_sys) #1 c += (wakeup_pulse === 1'b1);
        chk("wakeup pulses", c, 1);
        chk("wakeup style", wakeup_new_style, t == 0);
    endtask
    // ============
    // scenarios
    task automatic t_reset();
        logic [31:0] a [8] = '{UAMC_OFS_GUARD, UAMC_OFS_RATIO, UAMC_OFS_ERRS, UAMC_OFS_IRF,
                              UAMC_OFS_MAN, UAMC_OFS_LIN, UAMC_OFS_LINID, 32'hfff8c030};
        foreach (a[i]) begin
            rdc(a[i], (i == 1) ? 32'(UAMC_RATIO_RST) : 32'h0, "value after reset");
        end
    endtask
    task automatic t_guard();
        int c;
        int n [3] = '{0, 1, 255};
        foreach (n[i]) begin
            wr(UAMC_OFS_GUARD, n[i]);
            rdc(UAMC_OFS_GUARD, n[i], "guard readback");
            pulse(0);
            busy_len(1'b0, c);
            chk("guard span", n[i] == 0 ? c == 0 : c > (n[i] - 1) * BIT_DIV && c <= n[i] * BIT_DIV + 2, 1);
        end
    endtask
    task automatic t_baud();
        int r [4] = '{3, 1, 2047, 0};
        int w;
        int c;
        @(posedge clk_sys);
        op_mode <= UAMC_MODE_CARD;
        foreach (r[i]) begin
            wr(UAMC_OFS_RATIO, r[i]);
            w = (r[i] == 2047) ? 8200 : 240;
            c = 0;
            repeat (w) @(posedge clk_sys) #1 c += (baud_tick === 1'b1);
            chk("baud ticks", r[i] == 0 ? c == 0 : c - w / (2 * r[i]) inside {-1, 0, 1}, 1);
        end
    endtask
    task automatic t_errs();
        repeat (3) pulse(3);
        rdc(UAMC_OFS_ERRS, 3, "error count");
        rdc(UAMC_OFS_ERRS, 0, "error count after read");
        @(posedge clk_sys);
        op_mode <= 4'h0;
        pulse(3);
        rdc(UAMC_OFS_ERRS, 0, "error count outside card mode");
    endtask
    task automatic t_man();
        int c;
        wr(UAMC_OFS_IRF, 32'ha5);
        rdc(UAMC_OFS_IRF, 32'ha5, "filter readback");
        chk("filter output", ir_filter, 8'ha5);
        wr(UAMC_OFS_MAN, 32'h5209130f);
        rdc(UAMC_OFS_MAN, 32'h5209130f, "line code readback");
        chk("line code outputs", {rx_preamble_on, rx_preamble_length, tx_line_code_polarity,
            rx_line_code_polarity, drift_on}, 8'hcf);
        for (int pp = 0; pp < 4; pp++) begin
            // pattern 01 runs with tx polarity inverted, so it shows ones
            wr(UAMC_OFS_MAN, 32'h00010002 | (pp << 8) | (pp << 24) | (pp == 1 ? 32'h1000 : 32'h0));
            #1 if (pp < 2) chk("rx preamble level", rx_preamble_bit, pp == 0);
            chk("rx preamble on", rx_preamble_on, 1);
            pulse(1);
            busy_len(1'b1, c);
            chk("tx preamble span", c > BIT_DIV && c <= 2 * BIT_DIV + 2, 1);
            chk("tx preamble level", ones, pp < 2 ? c : pp == 2 ? BIT_DIV : c - BIT_DIV);
        end
        wr(UAMC_OFS_MAN, 32'h0);
        #1 chk("rx preamble off", {rx_preamble_on, drift_on}, 0);
        pulse(1);
        busy_len(1'b1, c);
        chk("tx preamble suppressed", c, 0);
    endtask
    task automatic t_lin();
        logic [31:0] w;
        logic [8:0]  dl [4] = '{9'h0, 9'hff, 9'h7, 9'h80};
        bit          p, k;
        for (int m = 0; m < 2; m++) begin
            @(posedge clk_sys);
            op_mode <= m ? UAMC_MODE_LIN_S : UAMC_MODE_LIN_M;
            // action code 11 stays unprogrammed
            for (int v = 0; v < 4; v++) begin
                p = v[0];
                k = v[1];
                w = {16'h0, dl[v][7:0], 1'b0, k, 1'b0, p, k, p, 2'(v % 3)};
                wr(UAMC_OFS_LIN, w);
                rdc(UAMC_OFS_LIN, w, "lin readback");
                chk("lin decode", {lin_master, lin_slave, tx_response, rx_response, gen_parity, chk_parity,
                    gen_checksum, chk_checksum, enhanced_checksum, frame_slot_on, response_bytes},
                    {m == 0, m == 1, v % 3 == 0, v % 3 == 1, m == 0 && !p, !p, m == 0 && !k, m == 1 && !k,
                    !p, !k, dl[v] + 9'h1});
            end
        end
        @(posedge clk_sys);
        op_mode <= UAMC_MODE_LIN_M;
        id_val  <= 8'h3c;
        for (int i = 0; i < 4; i++) begin
            wr(UAMC_OFS_LINID, 32'h1f | (i << 5));
            wr(UAMC_OFS_LIN, 32'h20);
            #1 chk("length from identifier", response_bytes, i < 2 ? 2 : 2 << (i - 1));
        end
        rdc(UAMC_OFS_LINID, 32'h7f, "identifier master");
        @(posedge clk_sys);
        op_mode <= UAMC_MODE_LIN_S;
        wr(UAMC_OFS_LINID, 32'h11);
        rdc(UAMC_OFS_LINID, 32'h7f, "identifier slave write");
        pulse(5);
        rdc(UAMC_OFS_LINID, 32'h3c, "identifier received");
        chk("identifier output", identifier_byte, 8'h3c);
        for (int t = 0; t < 2; t++) begin
            wr(UAMC_OFS_LIN, t << 7);
            pulse(2);
            wk_chk(t);
            wr(UAMC_OFS_LIN, 32'h20000 | (t << 7));
            wk_chk(t);
        end
        wr(UAMC_OFS_LIN, 32'h0);
        @(posedge clk_sys);
        dma_wdata <= 32'h1234;
        pulse(4);
        rdc(UAMC_OFS_LIN, 32'h0, "dma blocked");
        wr(UAMC_OFS_LIN, 32'h10000);
        pulse(4);
        rdc(UAMC_OFS_LIN, 32'h11234, "dma write");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ============
    // main sequence and watchdog
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
        t_guard();
        t_baud();
        t_errs();
        t_man();
        t_lin();
        tally_and_finish();
    end
    initial begin
        #120000;
        bad_count++;
        tally_and_finish();
    end
endmodule
